// File: rtl/sdram_refresh.sv
`timescale 1ns/1ps
// How it works
// - Refresh is CS, RAS, CAS low, WE high, CKE high at a rising edge.
// - Refresh ignores address, counts an internal row, leaves banks idle.
// - Self-refresh entry is CS, RAS, CAS, CKE low, WE high.
// - Enabled loop stops in self-refresh and restarts with a reset on a CKE exit; an exit by the reset pin with CKE still low gives no reset pulse.
// - In self-refresh only clock enable and reset are observed.
// - Device starts an internal refresh within one clock-enable pulse time.
module sdram_refresh (
   input wire logic sys_clk,
   input wire logic rst,
   input wire refresh_pkg::cmd_pins_t pins,
   input wire logic dllEnable,
   output logic inSelfRefresh_r,
   output logic refreshBusy_r,
   output logic dllOn_r,
   output logic dllResetPulse_r,
   output logic [15:0] refreshRow_r
);
   import refresh_pkg::*;

   // Pins come from the controller's domain; two flops before any use.
   cmd_pins_t meta_r, pinSync_r, pinPrev_r;
   mode_t mode_r;
   logic [15:0] busyCnt_r;
   logic [15:0] refiCnt_r;
   logic [15:0] srCnt_r;
   logic dllSync1_r, dllSync_r;

   always_ff @(posedge sys_clk) begin
      meta_r <= pins;
      pinSync_r <= meta_r;
      pinPrev_r <= pinSync_r;
      dllSync1_r <= dllEnable;
      dllSync_r <= dllSync1_r;
   end

   function automatic logic isRefCode(input cmd_pins_t p);
      return !p.csN && !p.rasN && !p.casN && p.weN;
   endfunction

   logic refCmd, sreCmd, srxCmd;
   // Refresh needs CKE high now and before; entry needs it falling.
   assign refCmd = isRefCode(pinSync_r) && pinSync_r.cke
      && pinPrev_r.cke;
   assign sreCmd = isRefCode(pinSync_r) && !pinSync_r.cke
      && pinPrev_r.cke;
   assign srxCmd = pinSync_r.cke;

   logic internalRef;
   assign internalRef = (mode_r == ST_SELF) &&
      (srCnt_r == 16'(CKE_PULSE_CYC - 1) ||
       refiCnt_r == 16'(REFI_CYC - 1));

   always_ff @(posedge sys_clk) begin
      if (rst || !pinSync_r.resetN) begin
         mode_r <= ST_IDLE;
         busyCnt_r <= 16'h0000;
         inSelfRefresh_r <= 1'b0;
         refreshBusy_r <= 1'b0;
      end else begin
         unique case (mode_r)
            ST_IDLE: begin
               if (sreCmd) begin
                  mode_r <= ST_SELF;
                  inSelfRefresh_r <= 1'b1;
               end else if (refCmd) begin
                  mode_r <= ST_REF;
                  refreshBusy_r <= 1'b1;
                  busyCnt_r <= 16'(RFC_CYC - 1);
               end
            end
            ST_REF: begin
               // Banks end precharged; no bank state is kept here.
               if (busyCnt_r == 16'h0000) begin
                  mode_r <= ST_IDLE;
                  refreshBusy_r <= 1'b0;
               end else begin
                  busyCnt_r <= busyCnt_r - 16'h0001;
               end
            end
            ST_SELF: begin
               // Only CKE and the reset pin (above) are looked at while in self-refresh.
               if (srxCmd) begin
                  mode_r <= ST_IDLE;
                  inSelfRefresh_r <= 1'b0;
               end
            end
            default: mode_r <= ST_IDLE;
         endcase
      end
   end

   // Internal timer for self-refresh; the first refresh comes early.
   always_ff @(posedge sys_clk) begin
      if (rst || mode_r != ST_SELF) begin
         srCnt_r <= 16'h0000;
         refiCnt_r <= 16'h0000;
      end else begin
         if (srCnt_r != 16'hFFFF)
            srCnt_r <= srCnt_r + 16'h0001;
         if (refiCnt_r == 16'(REFI_CYC - 1))
            refiCnt_r <= 16'h0000;
         else
            refiCnt_r <= refiCnt_r + 16'h0001;
      end
   end

   // Row counter advances on every refresh; address pins are never read.
   always_ff @(posedge sys_clk) begin
      if (rst)
         refreshRow_r <= ROW_RESET;
      else if ((mode_r == ST_IDLE && refCmd) || internalRef)
         refreshRow_r <= refreshRow_r + 16'h0001;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         dllOn_r <= 1'b0;
         dllResetPulse_r <= 1'b0;
      end else begin
         dllResetPulse_r <= 1'b0;
         if (mode_r == ST_IDLE && sreCmd)
            dllOn_r <= 1'b0;
         else if (mode_r == ST_SELF && srxCmd) begin
            dllOn_r <= dllSync_r;
            dllResetPulse_r <= dllSync_r;
         end else if (mode_r != ST_SELF)
            dllOn_r <= dllSync_r;
      end
   end

   // Checking helper: cycles that the busy flag has stood so far.
   // It saturates, so a stuck flag cannot wrap back to a legal length.
   logic [15:0] busyAge_r;

   always_ff @(posedge sys_clk) begin
      if (rst || !refreshBusy_r)
         busyAge_r <= 16'h0000;
      else if (busyAge_r != 16'hFFFF)
         busyAge_r <= busyAge_r + 16'h0001;
   end

   // Named steps for the checks below; only s_entry_seen is shared, by two checks.
   sequence s_entry_seen;
      mode_r == ST_IDLE && sreCmd && pinSync_r.resetN;
   endsequence

   sequence s_refresh_seen;
      mode_r == ST_IDLE && refCmd && pinSync_r.resetN;
   endsequence

   sequence s_exit_seen;
      mode_r == ST_SELF && srxCmd && pinSync_r.resetN;
   endsequence

   sequence s_busy_start;
      refreshBusy_r ##1 refreshBusy_r;
   endsequence

   // The reset pin is only seen through the synchroniser, so the checks
   // that could be cut short by it are disabled by, or gated on, its second flop.
   a_entry_sets_sr: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_entry_seen |=> inSelfRefresh_r)
      else $error("entry not taken");

   a_entry_dll_off: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_entry_seen |=> !dllOn_r)
      else $error("loop still on at entry");

   a_ref_busy_len: assert property (@(posedge sys_clk)
      disable iff (rst || !pinSync_r.resetN)
      s_refresh_seen |=> s_busy_start)
      else $error("refresh too short");

   a_busy_span: assert property (@(posedge sys_clk)
      disable iff (rst)
      $fell(refreshBusy_r) && $past(pinSync_r.resetN) && !$past(rst)
      |-> busyAge_r == 16'(RFC_CYC))
      else $error("refresh busy time wrong");

   a_sr_first_ref: assert property (@(posedge sys_clk)
      disable iff (rst)
      (mode_r == ST_SELF && srCnt_r == 16'(CKE_PULSE_CYC - 1))
      |=> $changed(refreshRow_r))
      else $error("no internal refresh");

   a_dll_off_sr: assert property (@(posedge sys_clk)
      disable iff (rst)
      inSelfRefresh_r && $past(inSelfRefresh_r) |-> !dllOn_r)
      else $error("loop on in self-refresh");

   a_exit_on_cke: assert property (@(posedge sys_clk)
      disable iff (rst)
      (mode_r == ST_SELF && srxCmd) |=> !inSelfRefresh_r)
      else $error("exit missed");

   a_exit_dll_reset: assert property (@(posedge sys_clk)
      disable iff (rst)
      s_exit_seen |=> dllResetPulse_r == $past(dllSync_r))
      else $error("loop reset pulse wrong on exit");

   a_pulse_single: assert property (@(posedge sys_clk)
      disable iff (rst)
      dllResetPulse_r |=> !dllResetPulse_r)
      else $error("loop reset pulse too long");

   a_pin_reset_idle: assert property (@(posedge sys_clk)
      disable iff (rst)
      !pinSync_r.resetN |=> !inSelfRefresh_r && !refreshBusy_r)
      else $error("reset pin not obeyed");

   a_row_steady: assert property (@(posedge sys_clk)
      disable iff (rst)
      !(mode_r == ST_IDLE && refCmd) && !internalRef
      |=> $stable(refreshRow_r))
      else $error("row moved without refresh");
endmodule

// File: pkg/refresh_pkg.sv
package refresh_pkg;

   localparam int CLK_MHZ = 40;
   // Minimum clock-enable pulse time in ns; internal refresh starts within it.
   localparam int CKE_PULSE_NS = 5;
   localparam int CKE_PULSE_CYC =
      (CKE_PULSE_NS * CLK_MHZ / 1000) < 1 ? 1 : (CKE_PULSE_NS * CLK_MHZ / 1000);
   // Average refresh interval of the internal timer, in ns.
   localparam int REFI_NS = 7800;
   localparam int REFI_CYC = REFI_NS * CLK_MHZ / 1000;
   // Refresh cycle time in ns; busy time of one refresh.
   localparam int RFC_NS = 160;
   localparam int RFC_CYC = (RFC_NS * CLK_MHZ + 999) / 1000;
   localparam int ROW_W = 16;
   localparam logic [ROW_W-1:0] ROW_RESET = 16'h0000;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic cke;
      logic resetN;
   } cmd_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SELF = 2'b01,
      ST_REF = 2'b10
   } mode_t;

endpackage

// File: sim/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model (
   input wire logic sys_clk,
   output refresh_pkg::cmd_pins_t pins
);
   import refresh_pkg::*;

   initial pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   // Pulls the device reset pin low for len cycles with the bus idle,
   // then leaves room for the synchroniser before the next command.
   task automatic pin_reset(input int len);
      @(negedge sys_clk);
      pins.resetN = 1'b0;
      repeat (len) @(negedge sys_clk);
      pins.resetN = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask
   // A command lasts one cycle, then the bus idles for hold cycles.
   // Callers pick holds that cover the busy and exit delays.
   task automatic cmd(input logic [3:0] c, input logic k, input int hold);
      @(negedge sys_clk);
      {pins.csN, pins.rasN, pins.casN, pins.weN} = c;
      pins.cke = k;
      @(negedge sys_clk);
      pins.csN = 1'b1;
      repeat (hold) @(negedge sys_clk);
   endtask
endmodule

// File: sim/sdram_refresh_tb.sv
`timescale 1ns/1ps
module sdram_refresh_tb;
   import refresh_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, dllEnable = 1'b1;
   cmd_pins_t pins;
   logic inSelfRefresh_r, refreshBusy_r, dllOn_r, dllResetPulse_r;
   logic [15:0] refreshRow_r, prevRow = 16'h0000, expRow = 16'h0000;
   logic [15:0] q[$];
   logic [15:0] expNow;
   int errors = 0, tests_run = 0, busyLen = 0, pulses = 0, p;
   ctrl_model i_ctrl_model (.sys_clk(sys_clk), .pins(pins));
   sdram_refresh i_sdram_refresh (.sys_clk(sys_clk), .rst(rst),
      .pins(pins), .dllEnable(dllEnable),
      .inSelfRefresh_r(inSelfRefresh_r), .refreshBusy_r(refreshBusy_r),
      .dllOn_r(dllOn_r), .dllResetPulse_r(dllResetPulse_r),
      .refreshRow_r(refreshRow_r));
   initial forever #12.5 sys_clk = ~sys_clk;
   task automatic check(input string n, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Outputs are read on the falling edge, where they have settled.
   always @(negedge sys_clk) if (rst === 1'b0) begin
      if (refreshRow_r !== prevRow) begin
         expNow = q.size() ? q.pop_front() : prevRow;
         check("row", refreshRow_r, expNow);
         prevRow = refreshRow_r;
      end
      if (refreshBusy_r === 1'b1) busyLen++;
      else if (busyLen != 0) begin
         check("busy", 16'(busyLen), 16'(RFC_CYC));
         busyLen = 0;
      end
      if (dllResetPulse_r === 1'b1) pulses++;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      finish_test();
   end
   initial begin
      void'($urandom(32734));
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      for (int i = 0; i < 3; i++) begin
         dllEnable = 1'($urandom);
         repeat (4) @(negedge sys_clk);
         check("dllOn", 16'(dllOn_r), 16'(dllEnable));
         for (int j = 0; j < 3; j++) begin
            expRow++;
            q.push_back(expRow);
            i_ctrl_model.cmd(4'b0001, 1'b1, RFC_CYC + 2 + $urandom % 4);
         end
         expRow++;
         q.push_back(expRow);
         i_ctrl_model.cmd(4'b0001, 1'b0, 4);
         check("self", 16'(inSelfRefresh_r), 16'h0001);
         check("dllOff", 16'(dllOn_r), 16'h0000);
         i_ctrl_model.cmd(4'($urandom), 1'b0, 30);
         check("stay", 16'(inSelfRefresh_r), 16'h0001);
         p = pulses;
         i_ctrl_model.cmd(4'b0111, 1'b1, 6);
         check("exit", 16'(inSelfRefresh_r), 16'h0000);
         check("dllRst", 16'(pulses - p), 16'(dllEnable));
      end
      // Extra refresh before re-entry, then the reset pin ends self-refresh.
      expRow++;
      q.push_back(expRow);
      i_ctrl_model.cmd(4'b0001, 1'b1, RFC_CYC + 2);
      expRow++;
      q.push_back(expRow);
      i_ctrl_model.cmd(4'b0001, 1'b0, 4);
      check("reEnter", 16'(inSelfRefresh_r), 16'h0001);
      i_ctrl_model.pin_reset(3);
      check("pinRst", 16'(inSelfRefresh_r), 16'h0000);
      p = pulses;
      i_ctrl_model.cmd(4'b0111, 1'b1, 6);
      check("noPulse", 16'(pulses - p), 16'h0000);
      check("dllBack", 16'(dllOn_r), 16'(dllEnable));
      check("left", 16'(q.size()), 16'h0000);
      finish_test();
   end
endmodule
